// >>> hdl/alo_adder.sv
`timescale 1ns/100ps
`default_nettype none
// Eight-bit adder with carry, half-byte carry and signed range flags
module alo_adder (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  alo_res_if.src          res
);
  logic [8:0] full;
  logic [4:0] low;
  // Sum and customary flag derivation
  always_comb begin
    full      = {1'b0, a} + {1'b0, b};
    low       = {1'b0, a[alo_pkg::NMSB:0]} + {1'b0, b[alo_pkg::NMSB:0]};
    res.sum   = full[alo_pkg::MSB:0];
    res.carry = full[alo_pkg::DW];
    res.half  = low[alo_pkg::NW];
    res.sovf  = (a[alo_pkg::MSB] == b[alo_pkg::MSB]) && (full[alo_pkg::MSB] != a[alo_pkg::MSB]);
  end
endmodule // alo_adder
`default_nettype wire

// >>> hdl/alo_pkg.sv
`default_nettype none
package alo_pkg;
  localparam int DW = 8;
  localparam int NW = 4;
  // Operation select codes from the decoder
  typedef enum logic [2:0] {
    ALO_OP_NONE     = 3'h0,
    ALO_OP_ADD_MEM  = 3'h1,
    ALO_OP_ADD_IMM  = 3'h2,
    ALO_OP_AND_MEM  = 3'h3,
    ALO_OP_AND_IMM  = 3'h4,
    ALO_OP_MASK_MEM = 3'h5,
    ALO_OP_ADD_ACC  = 3'h6
  } alo_op_t;
  localparam logic [DW-1:0] WREG_RST = 8'h00;
  localparam logic [DW-1:0] ZERO_B   = 8'h00;
  localparam int MSB = DW - 1;
  localparam int NMSB = NW - 1;
endpackage
`default_nettype wire

// >>> hdl/alo_res_if.sv
`timescale 1ns/100ps
`default_nettype none
// Result bundle from the arithmetic unit to the control
interface alo_res_if;
  logic [7:0] sum;
  logic       carry;
  logic       half;
  logic       sovf;
  modport src (output sum, output carry, output half, output sovf);
  modport dst (input sum, input carry, input half, input sovf);
endinterface
`default_nettype wire

// >>> hdl/alo_top.sv
// Function
// RULE1: Add-to-memory writes sum back to memory
// RULE2: Add-immediate puts sum in working register
// RULE3: AND-with-memory to working register, zero only
// RULE4: AND-immediate to working register, zero only
// RULE5: Mask-to-memory writes AND result to memory
// RULE6: Add sets range, zero, half, carry flags
`timescale 1ns/100ps
`default_nettype none
module alo_top (
  input  wire logic       CORE_CLK,
  input  wire logic       RESETN,
  input  wire logic       OP_VALID,
  input  wire logic [2:0] OP_SEL,
  input  wire logic [7:0] MEM_RDATA,
  input  wire logic [7:0] IMM_DATA,
  output logic      [7:0] WORK_REG,
  output logic            MEM_WE,
  output logic      [7:0] MEM_WDATA,
  output logic            ZERO_FLAG,
  output logic            CARRY_FLAG,
  output logic            HALF_BYTE_FLAG,
  output logic            SIGNED_RANGE_FLAG
);
  // Whole state of the block in one record
  typedef struct packed {
    logic [7:0] wreg;
    logic       we;
    logic [7:0] wdata;
    logic       z;
    logic       c;
    logic       h;
    logic       ov;
  } alo_state_t;

  // State, its next value and the decode helpers
  alo_state_t       st_ff;
  alo_state_t       nxt_st;
  alo_pkg::alo_op_t op;
  logic [7:0]       add_b;
  logic [7:0]       res_val;
  alo_res_if        add_res ();

  assign op    = alo_pkg::alo_op_t'(OP_SEL);
  assign add_b = (op == alo_pkg::ALO_OP_ADD_IMM) ? IMM_DATA : MEM_RDATA;

  // Shared adder
  alo_adder u_add (
    .a   (st_ff.wreg),
    .b   (add_b),
    .res (add_res)
  );

  // Bitwise mask shared by the three logic ops
  function automatic logic [7:0] and_bytes(input logic [7:0] x, input logic [7:0] y);
    return x & y;
  endfunction

  // Zero test shared by every op that sets the zero flag
  function automatic logic is_zero(input logic [7:0] v);
    return v == alo_pkg::ZERO_B;
  endfunction

  // Next-state decode per operation
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.we = 1'b0;
    res_val   = alo_pkg::ZERO_B;
    if (OP_VALID) begin
      case (op)
        // Sum of working register and memory byte to memory
        alo_pkg::ALO_OP_ADD_MEM: begin
          res_val      = add_res.sum;
          nxt_st.we    = 1'b1;                  // RULE1
          nxt_st.wdata = res_val;               // RULE1
          nxt_st.z     = is_zero(res_val);      // RULE6
          nxt_st.c     = add_res.carry;         // RULE6
          nxt_st.h     = add_res.half;          // RULE6
          nxt_st.ov    = add_res.sovf;          // RULE6
        end
        // Sum with the immediate into the working register
        alo_pkg::ALO_OP_ADD_IMM: begin
          res_val      = add_res.sum;
          nxt_st.wreg  = res_val;               // RULE2
          nxt_st.z     = is_zero(res_val);      // RULE6
          nxt_st.c     = add_res.carry;         // RULE6
          nxt_st.h     = add_res.half;          // RULE6
          nxt_st.ov    = add_res.sovf;          // RULE6
        end
        // Sum with the memory byte into the working register
        alo_pkg::ALO_OP_ADD_ACC: begin
          res_val      = add_res.sum;
          nxt_st.wreg  = res_val;
          nxt_st.z     = is_zero(res_val);      // RULE6
          nxt_st.c     = add_res.carry;         // RULE6
          nxt_st.h     = add_res.half;          // RULE6
          nxt_st.ov    = add_res.sovf;          // RULE6
        end
        // Mask with the memory byte into the working register
        alo_pkg::ALO_OP_AND_MEM: begin
          res_val      = and_bytes(st_ff.wreg, MEM_RDATA);
          nxt_st.wreg  = res_val;               // RULE3
          nxt_st.z     = is_zero(res_val);      // RULE3
        end
        // Mask with the immediate into the working register
        alo_pkg::ALO_OP_AND_IMM: begin
          res_val      = and_bytes(st_ff.wreg, IMM_DATA);
          nxt_st.wreg  = res_val;               // RULE4
          nxt_st.z     = is_zero(res_val);      // RULE4
        end
        // Mask written back to memory, zero flag too
        alo_pkg::ALO_OP_MASK_MEM: begin
          res_val      = and_bytes(MEM_RDATA, st_ff.wreg);
          nxt_st.we    = 1'b1;                  // RULE5
          nxt_st.wdata = res_val;               // RULE5
          nxt_st.z     = is_zero(res_val);
        end
        // Unknown codes drop the write strobe and leave all other state alone
        default: begin
          nxt_st.we = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_ff <= '{wreg: alo_pkg::WREG_RST, we: 1'b0, wdata: alo_pkg::ZERO_B,
                 z: 1'b0, c: 1'b0, h: 1'b0, ov: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign WORK_REG          = st_ff.wreg;
  assign MEM_WE            = st_ff.we;
  assign MEM_WDATA         = st_ff.wdata;
  assign ZERO_FLAG         = st_ff.z;
  assign CARRY_FLAG        = st_ff.c;
  assign HALF_BYTE_FLAG    = st_ff.h;
  assign SIGNED_RANGE_FLAG = st_ff.ov;

  // Checks on the memory write path
  a_add_mem_wb: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE1
    OP_VALID && op == alo_pkg::ALO_OP_ADD_MEM |=> MEM_WE
      && MEM_WDATA == 8'($past(WORK_REG) + $past(MEM_RDATA)))
    else $error("add to memory result wrong");
  a_add_mem_keep: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE1
    OP_VALID && op == alo_pkg::ALO_OP_ADD_MEM |=> $stable(WORK_REG))
    else $error("add to memory moved the working register");
  a_mask_mem_wb: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE5
    OP_VALID && op == alo_pkg::ALO_OP_MASK_MEM |=> MEM_WE
      && MEM_WDATA == ($past(WORK_REG) & $past(MEM_RDATA)) && $stable(WORK_REG))
    else $error("mask to memory wrong");
  a_mask_mem_flags: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE5
    OP_VALID && op == alo_pkg::ALO_OP_MASK_MEM |=> ZERO_FLAG == (MEM_WDATA == alo_pkg::ZERO_B)
      && $stable(CARRY_FLAG) && $stable(HALF_BYTE_FLAG) && $stable(SIGNED_RANGE_FLAG))
    else $error("mask to memory flags wrong");
  a_mem_we_src: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE1
    MEM_WE |-> $past(OP_VALID) && ($past(op) == alo_pkg::ALO_OP_ADD_MEM
      || $past(op) == alo_pkg::ALO_OP_MASK_MEM))
    else $error("memory write without a memory op");

  // Checks on working register results
  a_add_imm_wreg: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE2
    OP_VALID && op == alo_pkg::ALO_OP_ADD_IMM |=> !MEM_WE
      && WORK_REG == 8'($past(WORK_REG) + $past(IMM_DATA)))
    else $error("add immediate result wrong");
  a_add_acc_wreg: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE6
    OP_VALID && op == alo_pkg::ALO_OP_ADD_ACC |=> !MEM_WE
      && WORK_REG == 8'($past(WORK_REG) + $past(MEM_RDATA)))
    else $error("add memory to working register wrong");
  a_and_mem_wreg: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE3
    OP_VALID && op == alo_pkg::ALO_OP_AND_MEM |=> !MEM_WE
      && WORK_REG == ($past(WORK_REG) & $past(MEM_RDATA)) && $stable(CARRY_FLAG))
    else $error("and with memory wrong");
  a_and_imm_wreg: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE4
    OP_VALID && op == alo_pkg::ALO_OP_AND_IMM |=> WORK_REG == ($past(WORK_REG) & $past(IMM_DATA))
      && $stable(SIGNED_RANGE_FLAG) && $stable(HALF_BYTE_FLAG))
    else $error("and immediate wrong");
  a_idle_quiet: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE1 RULE2
    !OP_VALID |=> !MEM_WE && $stable(WORK_REG) && $stable(MEM_WDATA) && $stable(ZERO_FLAG)
      && $stable(CARRY_FLAG) && $stable(HALF_BYTE_FLAG) && $stable(SIGNED_RANGE_FLAG))
    else $error("outputs moved with no op");

  // Zero flag follows the stored result
  a_add_zero_flag: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE6
    OP_VALID && op == alo_pkg::ALO_OP_ADD_MEM |=> ZERO_FLAG == (MEM_WDATA == alo_pkg::ZERO_B))
    else $error("zero flag wrong after add");
  a_add_imm_zero: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE6
    OP_VALID && op == alo_pkg::ALO_OP_ADD_IMM |=> ZERO_FLAG == (WORK_REG == alo_pkg::ZERO_B))
    else $error("zero flag wrong after add immediate");
  a_and_mem_zero: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE3
    OP_VALID && op == alo_pkg::ALO_OP_AND_MEM |=> ZERO_FLAG == (WORK_REG == alo_pkg::ZERO_B)
      && $stable(HALF_BYTE_FLAG) && $stable(SIGNED_RANGE_FLAG))
    else $error("zero flag wrong after and with memory");
  a_and_imm_zero: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE4
    OP_VALID && op == alo_pkg::ALO_OP_AND_IMM |=> ZERO_FLAG == (WORK_REG == alo_pkg::ZERO_B)
      && $stable(CARRY_FLAG))
    else $error("zero flag wrong after and immediate");

  // Add flags from the eight-bit sum
  a_add_carry: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE6
    OP_VALID && op == alo_pkg::ALO_OP_ADD_IMM |=>
      CARRY_FLAG == (9'($past(WORK_REG)) + 9'($past(IMM_DATA)) > 9'h0ff))
    else $error("carry flag wrong");
  a_add_half: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE6
    OP_VALID && op == alo_pkg::ALO_OP_ADD_IMM |=> HALF_BYTE_FLAG ==
      (5'($past(WORK_REG[alo_pkg::NMSB:0])) + 5'($past(IMM_DATA[alo_pkg::NMSB:0])) > 5'h0f))
    else $error("half byte flag wrong");
  a_add_range: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE6
    OP_VALID && op == alo_pkg::ALO_OP_ADD_IMM |=> SIGNED_RANGE_FLAG ==
      (($past(WORK_REG[alo_pkg::MSB]) == $past(IMM_DATA[alo_pkg::MSB]))
      && (WORK_REG[alo_pkg::MSB] != $past(WORK_REG[alo_pkg::MSB]))))
    else $error("signed range flag wrong");
  a_add_acc_carry: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // RULE6
    OP_VALID && op == alo_pkg::ALO_OP_ADD_ACC |=>
      CARRY_FLAG == (9'($past(WORK_REG)) + 9'($past(MEM_RDATA)) > 9'h0ff)
      && HALF_BYTE_FLAG == (5'($past(WORK_REG[alo_pkg::NMSB:0])) + 5'($past(MEM_RDATA[alo_pkg::NMSB:0])) > 5'h0f))
    else $error("carry or half flag wrong after add memory");

  // Main scenarios reached
  c_add_mem: cover property (@(posedge CORE_CLK) OP_VALID && op == alo_pkg::ALO_OP_ADD_MEM ##1 CARRY_FLAG);
  c_and_zero: cover property (@(posedge CORE_CLK) OP_VALID && op == alo_pkg::ALO_OP_AND_MEM ##1 ZERO_FLAG);
  c_mask_mem: cover property (@(posedge CORE_CLK) OP_VALID && op == alo_pkg::ALO_OP_MASK_MEM ##1 MEM_WE);
  c_ovf: cover property (@(posedge CORE_CLK) OP_VALID && op == alo_pkg::ALO_OP_ADD_IMM ##1 SIGNED_RANGE_FLAG);
  c_mem_pair: cover property (@(posedge CORE_CLK) MEM_WE ##1 MEM_WE);
endmodule // alo_top
`default_nettype wire

// >>> sim/alo_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module alo_top_tb;
  logic       CORE_CLK = 1'h0;
  logic       RESETN = 1'h0;
  logic       OP_VALID = 1'h0;
  logic [2:0] OP_SEL = 3'h0;
  logic [7:0] MEM_RDATA = 8'h00;
  logic [7:0] IMM_DATA = 8'h00;
  logic [7:0] WORK_REG, MEM_WDATA;
  logic       MEM_WE, ZERO_FLAG, CARRY_FLAG, HALF_BYTE_FLAG, SIGNED_RANGE_FLAG;
  int         failures = 0;
  int         cmp_count = 0;
  alo_top dut_u (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .OP_VALID(OP_VALID), .OP_SEL(OP_SEL),
    .MEM_RDATA(MEM_RDATA), .IMM_DATA(IMM_DATA), .WORK_REG(WORK_REG), .MEM_WE(MEM_WE),
    .MEM_WDATA(MEM_WDATA), .ZERO_FLAG(ZERO_FLAG), .CARRY_FLAG(CARRY_FLAG),
    .HALF_BYTE_FLAG(HALF_BYTE_FLAG), .SIGNED_RANGE_FLAG(SIGNED_RANGE_FLAG));
  // Core clock, 100 ns period
  always #50 CORE_CLK = ~CORE_CLK;
  // Compare one value and count it
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Work reg, flags {range, zero, half, carry}, write strobe, write data
  task automatic look(input logic [7:0] w, input logic [3:0] f, input logic we, input logic [7:0] wd);
    chk(WORK_REG, w, "work reg");
    chk({4'h0, SIGNED_RANGE_FLAG, ZERO_FLAG, HALF_BYTE_FLAG, CARRY_FLAG}, {4'h0, f}, "flags");
    chk({7'h00, MEM_WE}, {7'h00, we}, "write strobe");
    chk(MEM_WDATA, wd, "write data");
  endtask
  // Present one op; returns just after the edge that takes it
  task automatic op(input logic [2:0] s, input logic [7:0] m, input logic [7:0] i);
    OP_VALID = 1'h1;
    OP_SEL = s;
    MEM_RDATA = m;
    IMM_DATA = i;
    @(posedge CORE_CLK);
    #1;
  endtask
  // One cycle with no op strobe
  task automatic idle;
    OP_VALID = 1'h0;
    @(posedge CORE_CLK);
    #1;
  endtask
  task automatic t_add_imm;
    op(alo_pkg::ALO_OP_ADD_IMM, 8'hAA, 8'h7F);
    look(8'h7F, 4'h0, 1'h0, 8'h00);
    op(alo_pkg::ALO_OP_ADD_IMM, 8'hAA, 8'h01);
    look(8'h80, 4'hA, 1'h0, 8'h00);
    $display("test add immediate done");
  endtask
  task automatic t_add_mem;
    op(alo_pkg::ALO_OP_ADD_MEM, 8'h80, 8'h55);
    look(8'h80, 4'hD, 1'h1, 8'h00);
    idle;
    look(8'h80, 4'hD, 1'h0, 8'h00);
    $display("test add to memory done");
  endtask
  // Back to back logic ops; only zero flag may move
  task automatic t_and;
    op(alo_pkg::ALO_OP_AND_MEM, 8'hC1, 8'h00);
    look(8'h80, 4'h9, 1'h0, 8'h00);
    op(alo_pkg::ALO_OP_MASK_MEM, 8'h81, 8'h00);
    look(8'h80, 4'h9, 1'h1, 8'h80);
    op(alo_pkg::ALO_OP_AND_IMM, 8'hFF, 8'h7F);
    look(8'h00, 4'hD, 1'h0, 8'h80);
    $display("test logic ops done");
  endtask
  task automatic t_add_acc;
    op(alo_pkg::ALO_OP_ADD_ACC, 8'h0F, 8'h00);
    look(8'h0F, 4'h0, 1'h0, 8'h80);
    op(alo_pkg::ALO_OP_ADD_ACC, 8'hF1, 8'h00);
    look(8'h00, 4'h7, 1'h0, 8'h80);
    $display("test add memory to work reg done");
  endtask
  // Unknown code and a dropped strobe change nothing
  task automatic t_refused;
    op(3'h7, 8'hFF, 8'hFF);
    look(8'h00, 4'h7, 1'h0, 8'h80);
    OP_SEL = alo_pkg::ALO_OP_ADD_IMM;
    idle;
    look(8'h00, 4'h7, 1'h0, 8'h80);
    $display("test ignored ops done");
  endtask
  // Memory ops back to back keep the write strobe high
  task automatic t_mem_pair;
    op(alo_pkg::ALO_OP_ADD_IMM, 8'h00, 8'h3C);
    look(8'h3C, 4'h0, 1'h0, 8'h80);
    op(alo_pkg::ALO_OP_ADD_MEM, 8'hC4, 8'h00);
    look(8'h3C, 4'h7, 1'h1, 8'h00);
    op(alo_pkg::ALO_OP_MASK_MEM, 8'h0F, 8'h00);
    look(8'h3C, 4'h3, 1'h1, 8'h0C);
    op(alo_pkg::ALO_OP_AND_MEM, 8'hC3, 8'h00);
    look(8'h00, 4'h7, 1'h0, 8'h0C);
    $display("test memory ops in a row done");
  endtask
  // Reset in mid run clears all; first op at the next edge
  task automatic t_reset_mid;
    OP_VALID = 1'h0;
    RESETN = 1'h0;
    @(posedge CORE_CLK);
    #1;
    look(8'h00, 4'h0, 1'h0, 8'h00);
    RESETN = 1'h1;
    op(alo_pkg::ALO_OP_ADD_IMM, 8'h00, 8'h01);
    look(8'h01, 4'h0, 1'h0, 8'h00);
    $display("test mid run reset done");
  endtask
  // Print counts and verdict, then stop
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge CORE_CLK);
    #1;
    RESETN = 1'h1;
    look(8'h00, 4'h0, 1'h0, 8'h00);
    $display("test reset done");
    t_add_imm;
    t_add_mem;
    t_and;
    t_add_acc;
    t_refused;
    t_mem_pair;
    t_reset_mid;
    end_of_test;
  end
  // Watchdog far beyond the 19 cycles needed
  initial begin
    #20000;
    failures++;
    end_of_test;
  end
endmodule // alo_top_tb
`default_nettype wire
